// [duh_consts.svh]
`ifndef DUH_CONSTS_SVH
`define DUH_CONSTS_SVH

// Host bus widths
`define DUH_DATA_W        8
`define DUH_ADDR_W        3

// Register offsets within one channel's set
`define DUH_REG_DATA      3'h0
`define DUH_REG_IEN       3'h1
`define DUH_REG_ISTAT     3'h2
`define DUH_REG_FCTL      3'h2
`define DUH_REG_LCTL      3'h3
`define DUH_REG_MCTL      3'h4
`define DUH_REG_LSTAT     3'h5
`define DUH_REG_MSTAT     3'h6
`define DUH_REG_SCRATCH   3'h7
`define DUH_REG_DIV_LO    3'h0
`define DUH_REG_DIV_HI    3'h1
`define DUH_REG_EFR       3'h2

// Field positions
`define DUH_FCR_FIFO_EN   0
`define DUH_FCR_BLOCK     3
`define DUH_LCR_DLAB      7
`define DUH_LSR_RX_DATA   0
`define DUH_LSR_THR_EMPTY 5
`define DUH_LSR_TX_EMPTY  6
`define DUH_LCR_ENH_KEY   8'hbf

// Reset values
`define DUH_RST_ZERO      8'h00
`define DUH_RST_DIV_LO    8'h01
`define DUH_RST_DIV_HI    8'h00
`define DUH_RST_LCR       8'h00
`define DUH_RST_ISR       8'h01
`define DUH_DIV_ZERO      8'h00

// Reset pulse timing
`define DUH_RST_MIN_NS    40
`define DUH_CLK_PERIOD_NS 4

`endif

// [duh_pkg.sv]
package duh_pkg;
    // Bus style chosen by the style strap
    typedef enum logic {
        DUH_BUS_RWLINE = 1'b0,
        DUH_BUS_STROBE = 1'b1
    } duh_bus_style_t;

    // Host access phase, Gray coded along idle, active, done
    typedef enum logic [1:0] {
        DUH_IDLE   = 2'b00,
        DUH_ACTIVE = 2'b01,
        DUH_DONE   = 2'b11
    } duh_phase_t;
endpackage : duh_pkg

// [duh_chan_if.sv]
`timescale 1ns/10ps
`include "duh_consts.svh"
// Per-channel access path from the host decoder to one register set
interface duh_chan_if;
    logic                      wr_pulse;
    logic                      rd_pulse;
    logic [`DUH_ADDR_W-1:0]    addr;
    logic [`DUH_DATA_W-1:0]    wdata;
    logic [`DUH_DATA_W-1:0]    rdata;
    logic                      fifo_en;
    logic                      block_mode;

    modport host (output wr_pulse, rd_pulse, addr, wdata, input rdata, fifo_en, block_mode);
    modport chan (input wr_pulse, rd_pulse, addr, wdata, output rdata, fifo_en, block_mode);
endinterface : duh_chan_if

// [duh_chan_regs.sv]
`timescale 1ns/10ps
`include "duh_consts.svh"
// One channel's independent register set, read data held in a register
module duh_chan_regs #(
    parameter logic [7:0] DEV_ID  = 8'h5a, // Arbitrary identification value
    parameter logic [7:0] DEV_REV = 8'h07  // Arbitrary revision value
) (
    input  wire logic   sys_clk,
    input  wire logic   rst,
    duh_chan_if.chan    bus,
    input  wire logic   thr_empty,
    input  wire logic   tx_idle,
    input  wire logic   rx_has_data,
    input  wire logic [7:0] rx_byte,
    input  wire logic [7:0] ist_in,
    input  wire logic [7:0] mst_in
);
    logic [7:0] ier;
    logic [7:0] fifo_control_reg;
    logic [7:0] lcr;
    logic [7:0] mcr;
    logic [7:0] spr;
    logic [7:0] dll;
    logic [7:0] divisor_high;
    logic [7:0] efr;
    logic [7:0] thr;
    logic [7:0] rd_q;
    logic [7:0] line_status_reg;
    logic       dlab;
    logic       id_mode;

    assign dlab    = lcr[`DUH_LCR_DLAB];
    assign id_mode = (dll == `DUH_DIV_ZERO) && (divisor_high == `DUH_DIV_ZERO); // RULE5

    // Receive-data and transmit status bits for the host
    always_comb begin
        line_status_reg = `DUH_RST_ZERO;
        line_status_reg[`DUH_LSR_RX_DATA]   = rx_has_data;
        line_status_reg[`DUH_LSR_THR_EMPTY] = thr_empty; // RULE15
        line_status_reg[`DUH_LSR_TX_EMPTY]  = tx_idle;   // RULE15
    end

    // Register writes, each channel fully separate
    always_ff @(posedge sys_clk) begin
        if (rst) begin // RULE3
            ier <= `DUH_RST_ZERO;
            fifo_control_reg <= `DUH_RST_ZERO;
            lcr <= `DUH_RST_LCR;
            mcr <= `DUH_RST_ZERO;
            spr <= `DUH_RST_ZERO;
            dll <= `DUH_RST_DIV_LO;
            divisor_high <= `DUH_RST_DIV_HI;
            efr <= `DUH_RST_ZERO;
            thr <= `DUH_RST_ZERO;
        end else if (bus.wr_pulse) begin // RULE16
            case (bus.addr)
                `DUH_REG_DATA: begin
                    if (dlab) dll <= bus.wdata;
                    else thr <= bus.wdata;
                end
                `DUH_REG_IEN: begin
                    if (dlab) divisor_high <= bus.wdata;
                    else ier <= bus.wdata;
                end
                `DUH_REG_FCTL: begin
                    if (lcr == `DUH_LCR_ENH_KEY) efr <= bus.wdata;
                    else fifo_control_reg <= bus.wdata; // RULE10
                end
                `DUH_REG_LCTL:    lcr <= bus.wdata;
                `DUH_REG_MCTL:    mcr <= bus.wdata;
                `DUH_REG_SCRATCH: spr <= bus.wdata;
                default: ;
            endcase
        end
    end

    // Read data captured on the read pulse; divisor reads show identity and revision when both zero
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rd_q <= `DUH_RST_ZERO;
        end else if (bus.rd_pulse) begin
            case (bus.addr)
                `DUH_REG_DATA:    rd_q <= dlab ? (id_mode ? DEV_REV : dll) : rx_byte; // RULE5
                `DUH_REG_IEN:     rd_q <= dlab ? (id_mode ? DEV_ID : divisor_high) : ier;      // RULE5
                `DUH_REG_ISTAT:   rd_q <= (lcr == `DUH_LCR_ENH_KEY) ? efr : ist_in;
                `DUH_REG_LCTL:    rd_q <= lcr;
                `DUH_REG_MCTL:    rd_q <= mcr;
                `DUH_REG_LSTAT:   rd_q <= line_status_reg;
                `DUH_REG_MSTAT:   rd_q <= mst_in;
                `DUH_REG_SCRATCH: rd_q <= spr;
                default:          rd_q <= `DUH_RST_ZERO;
            endcase
        end
    end

    assign bus.rdata      = rd_q;
    assign bus.fifo_en    = fifo_control_reg[`DUH_FCR_FIFO_EN];
    assign bus.block_mode = fifo_control_reg[`DUH_FCR_BLOCK];
endmodule : duh_chan_regs

// [duh_ready_pin.sv]
`timescale 1ns/10ps
// Ready-pin logic for one channel, registered outputs
module duh_ready_pin (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic fifo_en,
    input  wire logic block_mode,
    input  wire logic rx_empty,
    input  wire logic rx_trig,
    input  wire logic rx_timeout,
    input  wire logic tx_empty,
    input  wire logic tx_full,
    output logic      rx_ready_n,
    output logic      tx_ready_n
);
    // Receive pin: level in single mode, set/hold in block mode
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rx_ready_n <= 1'b1;
        end else if (!fifo_en || !block_mode) begin
            rx_ready_n <= rx_empty; // RULE11
        end else if (rx_trig || rx_timeout) begin
            rx_ready_n <= 1'b0; // RULE13
        end else if (rx_empty) begin
            rx_ready_n <= 1'b1; // RULE13
        end
    end

    // Transmit pin: empty-paced in single mode, full-paced in block mode
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tx_ready_n <= 1'b0;
        end else if (fifo_en && block_mode) begin
            tx_ready_n <= tx_full; // RULE14
        end else begin
            tx_ready_n <= !tx_empty; // RULE12
        end
    end
endmodule : duh_ready_pin

// [duh_host_port.sv]
`timescale 1ns/10ps
`include "duh_consts.svh"
// Notes on behaviour
// RULE1: Shared 8-bit data bus and 3 address lines serve both channels.
// RULE2: Host cycles decode from selects and strobes, no serial clock.
// RULE3: Reset over 40 ns restores registers and outputs of both channels.
// RULE4: Reset active high in strobe style, low in read/write style.
// RULE5: Both divisors zero: high divisor reads identity, low reads revision.
// RULE6: Style strap high picks strobe bus, low read/write-line bus.
// RULE7: Strobe style: A low picks A, B low B, both write both.
// RULE8: Host never reads with both selects asserted.
// RULE9: Read/write style: select low, address bit picks channel.
// RULE10: Block bit clear gives single-character mode, set gives block mode.
// RULE11: Single mode: receive ready low while receive FIFO not empty.
// RULE12: Single mode: transmit ready low only when transmit FIFO empty.
// RULE13: Block mode: receive ready falls at trigger or time-out, rises at empty.
// RULE14: Block mode: transmit ready low while transmit FIFO not full.
// RULE15: Line status bits 5 and 6 show transmitter empty and space; the code puts space in bit 5 and transmitter empty in bit 6.
// RULE16: Each channel has its own register set.
// RULE17: Ready logic takes FIFO occupancy, trigger and time-out inputs.
module duh_host_port #(
    parameter logic [7:0] DEV_ID  = 8'h5a, // Arbitrary identification value
    parameter logic [7:0] DEV_REV = 8'h07  // Arbitrary revision value
) (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        reset_pin,
    input  wire logic        bus_style,
    input  wire logic        chan_a_select_n,
    input  wire logic        chan_b_select_n,
    input  wire logic        channel_addr_bit,
    input  wire logic        read_strobe_n,
    input  wire logic        write_strobe_n,
    input  wire logic [2:0]  addr,
    input  wire logic [7:0]  data_in,
    output logic      [7:0]  data_out,
    output logic             data_oe,
    output logic             chip_reset,
    input  wire logic [1:0]  rx_empty,
    input  wire logic [1:0]  rx_trig,
    input  wire logic [1:0]  rx_timeout,
    input  wire logic [1:0]  tx_empty,
    input  wire logic [1:0]  tx_full,
    input  wire logic [1:0]  tx_idle,
    input  wire logic [15:0] rx_byte,
    input  wire logic [15:0] ist_in,
    input  wire logic [15:0] mst_in,
    output logic      [1:0]  rx_ready_n,
    output logic      [1:0]  tx_ready_n,
    output logic      [1:0]  fifo_en,
    output logic      [1:0]  block_mode
);
    localparam int RST_CYC_RAW = (`DUH_RST_MIN_NS + `DUH_CLK_PERIOD_NS - 1) / `DUH_CLK_PERIOD_NS;
    localparam int RST_CYC     = (RST_CYC_RAW < 1) ? 1 : RST_CYC_RAW;
    localparam int SYNC_W      = 18;

    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
    logic [SYNC_W-1:0] raw;
    logic       style;
    logic       cs_a_n;
    logic       cs_b_n;
    logic       a3;
    logic       rd_n;
    logic       wr_n;
    logic       rst_pin_s;
    logic [2:0] addr_s;
    logic [7:0] wdata_s;
    logic       rst_act;
    logic [3:0] rst_cnt;
    logic       sel_a;
    logic       sel_b;
    logic       rd_req;
    logic       wr_req;
    logic       next_rd_pulse;
    logic       next_wr_pulse;
    logic       dev_rst;
    logic       rd_pend;
    logic       rd_chan_b;
    duh_pkg::duh_phase_t phase;
    duh_pkg::duh_phase_t next_phase;

    duh_chan_if ch_a ();
    duh_chan_if ch_b ();

    assign raw = {bus_style, chan_a_select_n, chan_b_select_n, channel_addr_bit,
                  read_strobe_n, write_strobe_n, reset_pin, addr, data_in};

    // Pins come from outside, two flops before any logic sees them
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sync1 <= {SYNC_W{1'b1}};
            sync2 <= {SYNC_W{1'b1}};
        end else begin
            sync1 <= raw;
            sync2 <= sync1;
        end
    end

    assign style     = sync2[17];
    assign cs_a_n    = sync2[16];
    assign cs_b_n    = sync2[15];
    assign a3        = sync2[14];
    assign rd_n      = sync2[13];
    assign wr_n      = sync2[12];
    assign rst_pin_s = sync2[11];
    assign addr_s    = sync2[10:8];
    assign wdata_s   = sync2[7:0];

    // Reset pin polarity set by the bus style strap
    assign rst_act = (style == duh_pkg::DUH_BUS_STROBE) ? rst_pin_s : !rst_pin_s; // RULE4

    // Pin reset must stand for the minimum pulse before it takes effect
    always_ff @(posedge sys_clk) begin
        if (rst || !rst_act) begin
            rst_cnt <= 4'h0;
        end else if (rst_cnt != RST_CYC[3:0]) begin
            rst_cnt <= rst_cnt + 4'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dev_rst <= 1'b1;
        end else begin
            dev_rst <= rst_act && (rst_cnt == RST_CYC[3:0]); // RULE3
        end
    end

    // Channel decode per bus style
    always_comb begin
        if (style == duh_pkg::DUH_BUS_STROBE) begin // RULE6
            sel_a  = !cs_a_n; // RULE7
            sel_b  = !cs_b_n; // RULE7
            rd_req = !rd_n && (sel_a ^ sel_b); // RULE8
            wr_req = !wr_n && (sel_a || sel_b);
        end else begin
            sel_a  = !cs_a_n && !a3; // RULE9
            sel_b  = !cs_a_n && a3;  // RULE9
            rd_req = !cs_a_n && wr_n;
            wr_req = !cs_a_n && !wr_n;
        end
    end

    // One pulse per strobe: act once, then wait for the strobe to go away
    always_comb begin
        next_phase    = phase;
        next_rd_pulse = 1'b0;
        next_wr_pulse = 1'b0;
        case (phase)
            duh_pkg::DUH_IDLE: begin
                if (wr_req) begin
                    next_wr_pulse = 1'b1;
                    next_phase    = duh_pkg::DUH_ACTIVE;
                end else if (rd_req) begin
                    next_rd_pulse = 1'b1;
                    next_phase    = duh_pkg::DUH_ACTIVE;
                end
            end
            duh_pkg::DUH_ACTIVE: next_phase = duh_pkg::DUH_DONE;
            duh_pkg::DUH_DONE: begin
                if (!rd_req && !wr_req) next_phase = duh_pkg::DUH_IDLE;
            end
            default: next_phase = duh_pkg::DUH_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst || dev_rst) begin
            phase <= duh_pkg::DUH_IDLE;
        end else begin
            phase <= next_phase; // RULE2
        end
    end

    // Access pulses fan out to the selected register sets
    always_comb begin
        ch_a.wr_pulse = next_wr_pulse && sel_a; // RULE7
        ch_b.wr_pulse = next_wr_pulse && sel_b;
        ch_a.rd_pulse = next_rd_pulse && sel_a;
        ch_b.rd_pulse = next_rd_pulse && sel_b;
        ch_a.addr     = addr_s; // RULE1
        ch_b.addr     = addr_s;
        ch_a.wdata    = wdata_s;
        ch_b.wdata    = wdata_s;
    end

    // Remember which channel answers the pending read
    always_ff @(posedge sys_clk) begin
        if (rst || dev_rst) begin
            rd_pend   <= 1'b0;
            rd_chan_b <= 1'b0;
        end else begin
            rd_pend <= next_rd_pulse;
            if (next_rd_pulse) rd_chan_b <= sel_b;
        end
    end

    // Shared data bus, driven while the read strobe stands
    always_ff @(posedge sys_clk) begin
        if (rst || dev_rst) begin
            data_out <= 8'h00;
            data_oe  <= 1'b0;
        end else begin
            if (rd_pend) data_out <= rd_chan_b ? ch_b.rdata : ch_a.rdata; // RULE1
            data_oe <= (phase != duh_pkg::DUH_IDLE) && rd_req;
        end
    end

    // Reset seen by the serial engines of both channels
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            chip_reset <= 1'b1;
        end else begin
            chip_reset <= dev_rst; // RULE3
        end
    end

    // Mode bits reported to the FIFO blocks
    always_ff @(posedge sys_clk) begin
        if (rst || dev_rst) begin
            fifo_en    <= 2'h0;
            block_mode <= 2'h0;
        end else begin
            fifo_en    <= {ch_b.fifo_en, ch_a.fifo_en};
            block_mode <= {ch_b.block_mode, ch_a.block_mode}; // RULE10
        end
    end

    duh_chan_regs #(.DEV_ID(DEV_ID), .DEV_REV(DEV_REV)) u_regs_a (
        .sys_clk     (sys_clk),
        .rst         (rst || dev_rst),
        .bus         (ch_a),
        .thr_empty   (!tx_full[0]),
        .tx_idle     (tx_idle[0]),
        .rx_has_data (!rx_empty[0]),
        .rx_byte     (rx_byte[7:0]),
        .ist_in      (ist_in[7:0]),
        .mst_in      (mst_in[7:0])
    ); // RULE16

    duh_chan_regs #(.DEV_ID(DEV_ID), .DEV_REV(DEV_REV)) u_regs_b (
        .sys_clk     (sys_clk),
        .rst         (rst || dev_rst),
        .bus         (ch_b),
        .thr_empty   (!tx_full[1]),
        .tx_idle     (tx_idle[1]),
        .rx_has_data (!rx_empty[1]),
        .rx_byte     (rx_byte[15:8]),
        .ist_in      (ist_in[15:8]),
        .mst_in      (mst_in[15:8])
    );

    // Ready pins per channel fed by FIFO status inputs
    duh_ready_pin u_rdy_a (
        .sys_clk    (sys_clk),
        .rst        (rst || dev_rst),
        .fifo_en    (ch_a.fifo_en),
        .block_mode (ch_a.block_mode),
        .rx_empty   (rx_empty[0]),
        .rx_trig    (rx_trig[0]),
        .rx_timeout (rx_timeout[0]),
        .tx_empty   (tx_empty[0]),
        .tx_full    (tx_full[0]),
        .rx_ready_n (rx_ready_n[0]),
        .tx_ready_n (tx_ready_n[0])
    ); // RULE17

    duh_ready_pin u_rdy_b (
        .sys_clk    (sys_clk),
        .rst        (rst || dev_rst),
        .fifo_en    (ch_b.fifo_en),
        .block_mode (ch_b.block_mode),
        .rx_empty   (rx_empty[1]),
        .rx_trig    (rx_trig[1]),
        .rx_timeout (rx_timeout[1]),
        .tx_empty   (tx_empty[1]),
        .tx_full    (tx_full[1]),
        .rx_ready_n (rx_ready_n[1]),
        .tx_ready_n (tx_ready_n[1])
    ); // RULE17
endmodule : duh_host_port

// [duh_host_port_checker.sv]
`timescale 1ns/10ps
// Port checks: read drive, reset pin, ready pins
module duh_host_port_checker (
    input wire logic       sys_clk,
    input wire logic       rst,
    input wire logic       reset_pin,
    input wire logic       bus_style,
    input wire logic       chan_a_select_n,
    input wire logic       chan_b_select_n,
    input wire logic       read_strobe_n,
    input wire logic       write_strobe_n,
    input wire logic       data_oe,
    input wire logic       chip_reset,
    input wire logic [1:0] rx_empty,
    input wire logic [1:0] rx_trig,
    input wire logic [1:0] rx_timeout,
    input wire logic [1:0] tx_empty,
    input wire logic [1:0] tx_full,
    input wire logic [1:0] rx_ready_n,
    input wire logic [1:0] tx_ready_n,
    input wire logic [1:0] fifo_en,
    input wire logic [1:0] block_mode
);
    logic       pin_act;
    logic       rd_pin;
    logic [4:0] act_cnt;
    // Pin polarity follows the strap; a read with both selects low is no read at all
    assign pin_act = (reset_pin == bus_style);
    assign rd_pin  = bus_style ? (!read_strobe_n && (chan_a_select_n ^ chan_b_select_n))
                               : (!chan_a_select_n && write_strobe_n);
    // Length of the current reset pulse, saturating so a long hold stays counted
    always_ff @(posedge sys_clk) begin
        if (rst || !pin_act) begin
            act_cnt <= 5'h00;
        end else if (act_cnt != 5'h1f) begin
            act_cnt <= act_cnt + 5'h01;
        end
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    chk_oe_source: assert property (
        $rose(data_oe) |-> $past(rd_pin, 2))
        else $error("data bus driven without a read");
    chk_oe_release: assert property (
        !rd_pin [*4] |-> !data_oe)
        else $error("data bus still driven after read ended");
    chk_pin_reset: assert property (
        act_cnt == 5'h10 |-> chip_reset)
        else $error("long reset pulse did not reset");
    chk_pin_quiet: assert property (
        !pin_act [*8] |-> !chip_reset)
        else $error("reset without an active reset pin");
    chk_rx_single: assert property (
        (fifo_en[0] && !block_mode[0] && $stable(rx_empty[0])) [*3]
        |-> rx_ready_n[0] == rx_empty[0])
        else $error("receive ready wrong in single mode");
    chk_tx_single: assert property (
        (fifo_en[0] && !block_mode[0] && $stable(tx_empty[0])) [*3]
        |-> tx_ready_n[0] == !tx_empty[0])
        else $error("transmit ready wrong in single mode");
    chk_tx_block: assert property (
        (fifo_en[0] && block_mode[0] && $stable(tx_full[0])) [*3]
        |-> tx_ready_n[0] == tx_full[0])
        else $error("transmit ready wrong in block mode");
    chk_rx_blk_fall: assert property (
        (fifo_en[1] && block_mode[1] && !rx_empty[1] && (rx_trig[1] || rx_timeout[1])) [*3]
        |-> !rx_ready_n[1])
        else $error("receive ready did not fall at trigger");
    chk_rx_blk_rise: assert property (
        (fifo_en[0] && block_mode[0] && rx_empty[0]) [*3] |-> rx_ready_n[0])
        else $error("receive ready did not rise when empty");
    chk_rx_blk_hold: assert property (
        (fifo_en[0] && block_mode[0] && !rx_empty[0]) [*4] ##0 !rx_ready_n[0]
        |=> !rx_ready_n[0])
        else $error("receive ready rose before empty");
endmodule : duh_host_port_checker
bind duh_host_port duh_host_port_checker chk (.*);

// [duh_host_model.sv]
`timescale 1ns/10ps
// Host processor on the byte bus: drives just after an edge, holds a write 5 cycles and a read until answered or 12 cycles pass
module duh_host_model (
    input  wire logic       sys_clk,
    input  wire logic [7:0] data_out,
    input  wire logic       data_oe,
    output logic            reset_pin,
    output logic            bus_style,
    output logic            chan_a_select_n,
    output logic            chan_b_select_n,
    output logic            channel_addr_bit,
    output logic            read_strobe_n,
    output logic            write_strobe_n,
    output logic [2:0]      addr,
    output logic [7:0]      data_in
);
    initial begin
        bus_style = 1'b1;
        reset_pin = 1'b0;
        channel_addr_bit = 1'b0;
        addr = 3'h0;
        data_in = 8'h00;
        idle();
    end
    // Strap and pin move together so the device never sees reset active
    task automatic set_style(input logic s);
        bus_style = s;
        reset_pin = ~s;
    endtask : set_style
    // Callers keep the pulse well beyond 40 ns
    task automatic pin_reset(input int n);
        @(posedge sys_clk);
        #1 reset_pin = bus_style;
        repeat (n) @(posedge sys_clk);
        #1 reset_pin = ~bus_style;
    endtask : pin_reset
    // Released address and data lines show the inverse of their last value, never a stale copy
    task automatic idle();
        chan_a_select_n = 1'b1;
        chan_b_select_n = bus_style ? 1'b1 : 1'($urandom);
        read_strobe_n = bus_style ? 1'b1 : 1'($urandom);
        write_strobe_n = 1'b1;
        addr = ~addr;
        data_in = ~data_in;
    endtask : idle
    // One byte access; sel bit0 is channel A, bit1 channel B
    task automatic xfer(input logic [1:0] sel, input logic wr, input logic [2:0] a,
                        input logic [7:0] d, output logic [7:0] q, output logic ok);
        @(posedge sys_clk);
        #1;
        addr = a;
        data_in = d;
        write_strobe_n = ~wr;
        if (bus_style) begin
            chan_a_select_n = ~sel[0];
            chan_b_select_n = ~sel[1];
            read_strobe_n = wr;
            channel_addr_bit = 1'($urandom);
        end else begin
            chan_a_select_n = 1'b0;
            chan_b_select_n = 1'($urandom);
            channel_addr_bit = sel[1];
        end
        ok = wr;
        q = 8'h00;
        repeat (wr ? 5 : 0) @(posedge sys_clk);
        for (int i = 0; i < 12 && !ok; i++) begin
            @(posedge sys_clk);
            if (data_oe === 1'b1) begin
                q = data_out;
                ok = 1'b1;
            end
        end
        #1 idle();
        repeat (3) @(posedge sys_clk);
    endtask : xfer
endmodule : duh_host_model

// [duh_host_port_test.sv]
`timescale 1ns/10ps
module duh_host_port_test;
    localparam logic [7:0] ID  = 8'h3c; // Arbitrary identification value
    localparam logic [7:0] REV = 8'h02; // Arbitrary revision value
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    wire         reset_pin, bus_style, chan_a_select_n, chan_b_select_n, channel_addr_bit;
    wire         read_strobe_n, write_strobe_n, data_oe, chip_reset;
    wire  [2:0]  addr;
    wire  [7:0]  data_in, data_out;
    wire  [1:0]  rx_ready_n, tx_ready_n, fifo_en, block_mode;
    logic [1:0]  rx_empty = 2'h3, rx_trig = 2'h0, rx_timeout = 2'h0;
    logic [1:0]  tx_empty = 2'h3, tx_full = 2'h0, tx_idle = 2'h3, exp_rx = 2'h3;
    logic [15:0] rx_byte = 16'h0000, ist_in = 16'h0000, mst_in = 16'h0000;
    logic [7:0]  fcr_tbl [3] = '{8'h00, 8'h01, 8'h09};
    int          err_total = 0;
    int          n_compared = 0;

    initial forever #2 sys_clk = ~sys_clk;

    duh_host_port #(.DEV_ID(ID), .DEV_REV(REV)) dut (.*);

    duh_host_model host (.*);

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [1:0] sel, input logic [2:0] a, input logic [7:0] d);
        logic [7:0] q;
        logic       ok;
        host.xfer(sel, 1'b1, a, d, q, ok);
    endtask : wr
    // Answered read, masked compare
    task automatic rd(input logic [1:0] sel, input logic [2:0] a, input logic [7:0] e,
                      input logic [7:0] m = 8'hff);
        logic [7:0] q;
        logic       ok;
        host.xfer(sel, 1'b0, a, 8'h00, q, ok);
        chk({7'h00, ok}, 8'h01);
        chk(q & m, e & m);
    endtask : rd
    // Expected {tx, rx} pins; block mode holds rx
    function automatic logic [1:0] ready_exp(input logic blk, input int c);
        logic rx;
        logic tx;
        rx = rx_empty[c] ? 1'b1 : (blk && !(rx_trig[c] | rx_timeout[c])) ? exp_rx[c] : 1'b0;
        tx = blk ? tx_full[c] : ~tx_empty[c];
        exp_rx[c] = rx;
        return {tx, rx};
    endfunction : ready_exp

    task automatic print_verdict();
        $display("compared %0d errors %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : print_verdict

    // Hang guard, far past the run length
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_total++;
        $display("[ERR] %0t got %h exp %h", $time, 1'b0, 1'b1);
        print_verdict();
    end

    initial begin
        logic [7:0] v;
        logic [7:0] w;
        logic [1:0] e;
        logic [1:0] s;
        logic       ok;
        void'($urandom(64225));
        repeat (20) @(posedge sys_clk);
        #1 rst = 1'b0;
        // Both selects write one byte to both channels over the shared bus
        v = 8'($urandom);
        wr(2'h3, 3'h7, v);
        rd(2'h1, 3'h7, v);
        rd(2'h2, 3'h7, v);
        // Each bus style: private scratch per channel, pin reset, identity readout
        for (int b = 1; b >= 0; b--) begin
            #1 host.set_style(1'(b));
            repeat (4) @(posedge sys_clk);
            v = 8'($urandom);
            w = ~v;
            wr(2'h1, 3'h7, v);
            wr(2'h2, 3'h7, w);
            rd(2'h1, 3'h7, v);
            rd(2'h2, 3'h7, w);
            host.pin_reset(18);
            chk({7'h00, chip_reset}, 8'h01);
            repeat (6) @(posedge sys_clk);
            for (int c = 0; c < 2; c++) begin
                s = 2'(c + 1);
                rd(s, 3'h7, 8'h00);
                wr(s, 3'h3, 8'h80);
                rd(s, 3'h0, 8'h01);
                rd(s, 3'h1, 8'h00);
                wr(s, 3'h0, 8'h00);
                rd(s, 3'h1, ID);
                rd(s, 3'h0, REV);
                wr(s, 3'h3, 8'h00);
            end
        end
        #1 host.set_style(1'b1);
        repeat (4) @(posedge sys_clk);
        // A read with both selects must go unanswered
        host.xfer(2'h3, 1'b0, 3'h7, 8'h00, v, ok);
        chk({7'h00, ok}, 8'h00);
        // Ready pins per FIFO mode against random occupancy
        foreach (fcr_tbl[m]) begin
            wr(2'h3, 3'h2, fcr_tbl[m]);
            chk({6'h00, fifo_en}, {6'h00, {2{fcr_tbl[m][0]}}});
            chk({6'h00, block_mode}, {6'h00, {2{fcr_tbl[m][3]}}});
            for (int i = 0; i < 24; i++) begin
                @(posedge sys_clk);
                #1;
                rx_empty = (i == 0) ? 2'h3 : 2'($urandom);
                rx_trig = 2'($urandom) & ~rx_empty;
                rx_timeout = 2'($urandom) & 2'($urandom) & ~rx_empty;
                tx_empty = 2'($urandom);
                tx_full = 2'($urandom) & ~tx_empty;
                tx_idle = 2'($urandom);
                {rx_byte, ist_in, mst_in} = {16'($urandom), 32'($urandom)};
                repeat (4) @(posedge sys_clk);
                for (int c = 0; c < 2; c++) begin
                    e = ready_exp(fcr_tbl[m][3] & fcr_tbl[m][0], c);
                    chk({7'h00, rx_ready_n[c]}, {7'h00, e[0]});
                    chk({7'h00, tx_ready_n[c]}, {7'h00, e[1]});
                end
                if (i % 4 == 0) begin
                    rd(i[2] ? 2'h2 : 2'h1, 3'h5, {1'b0, tx_idle[i[2]], ~tx_full[i[2]], 5'h00},
                       8'h60);
                end
            end
        end
        print_verdict();
    end
endmodule : duh_host_port_test
